// ==== inc/ddac_pkg.sv ====
`default_nettype none
package ddac_pkg;
    localparam logic [4:0] A_CAL_CTRL = 5'h0E;
    localparam logic [4:0] A_CAL_MEM = 5'h0F;
    localparam logic [4:0] A_MEM_ADDR = 5'h10;
    localparam logic [4:0] A_MEM_DATA = 5'h11;
    localparam logic [4:0] A_CAL_CMD = 5'h12;
    localparam logic [4:0] A_RT_CTRL = 5'h14;
    localparam logic [4:0] A_HW_REV = 5'h1F;
    // Control and status bit positions, and the memory address bit B_HALF
    localparam int B_PRELD_Q = 7;
    localparam int B_PRELD_I = 6;
    localparam int B_SEL_Q = 5;
    localparam int B_SEL_I = 4;
    localparam int B_CAL_CLOCK_ENABLE_EN = 3;
    localparam int B_CLR_Q = 7;
    localparam int B_CLR_I = 6;
    localparam int B_START = 4;
    localparam int B_STORE = 3;
    localparam int B_FETCH = 2;
    localparam int B_UNCAL_Q = 1;
    localparam int B_UNCAL_I = 0;
    localparam int B_SEARCH = 4;
    localparam int B_REACQ = 3;
    localparam int B_OVR = 2;
    localparam int B_HALF = 5;
    localparam logic [5:0] CAL_REF_FIXED = 6'h20;
    localparam logic [5:0] USER_REF_ADDR = 6'h01;
    localparam logic [5:0] COEFF_DEFAULT = 6'h00;
    localparam logic [1:0] MEM_UNCAL = 2'h0;
    localparam logic [1:0] MEM_SELF = 2'h1;
    localparam logic [1:0] MEM_USER = 2'h2;
    // Arbitrary revision value
    localparam logic [7:0] HW_REVISION = 8'h01;
    localparam logic [7:0] RT_ACQ_CYCLES = 8'h64;
    localparam logic [5:0] CAL_RUN_TICKS = 6'h20;
    localparam logic [4:0] SPI_BITS = 5'h10;
    localparam logic [4:0] SPI_INSTR_BITS = 5'h08;
    localparam int SAMPLE_W = 14;
    localparam int FIFO_DEPTH = 16;
    typedef struct packed {
        logic [SAMPLE_W-1:0] i;
        logic [SAMPLE_W-1:0] q;
    } ddac_pair_t;
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN = 2'b01,
        CAL_FINISH = 2'b11
    } ddac_cal_st_t;
endpackage
`default_nettype wire

// ==== rtl/ddac_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module ddac_fifo #(
    parameter int W = 28,
    parameter int D = 16
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [W-1:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    output logic [W-1:0] o_data,
    output logic o_valid,
    input wire logic i_ready
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } ddac_fifo_st_t;
    ddac_fifo_st_t f_reg;
    ddac_fifo_st_t f_next;
    logic push;
    logic pop;

    always_comb
    begin
        push = i_valid && o_ready;
        pop = o_valid && i_ready;
        f_next = f_reg;
        if (push)
        begin
            f_next.mem[f_reg.wp] = i_data;
            f_next.wp = f_reg.wp + 1'b1;
        end
        if (pop)
        begin
            f_next.rp = f_reg.rp + 1'b1;
        end
        f_next.cnt = f_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            f_reg <= '0;
        else
            f_reg <= f_next;
    end

    assign o_ready = f_reg.cnt != D[AW:0];
    assign o_valid = f_reg.cnt != '0;
    assign o_data = f_reg.mem[f_reg.rp];
endmodule

////////////////////////////////////////////////////////////////////////////////
module ddac_top (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_spi_clk,
    input wire logic i_spi_cs_n,
    input wire logic i_sdio,
    output logic o_sdio,
    output logic o_sdio_oe,
    input wire logic i_data_qualifying_clock,
    input wire logic [ddac_pkg::SAMPLE_W-1:0] i_sample_data_bus,
    input wire logic i_channel_order_select,
    input wire logic i_sample_edge_select,
    input wire logic i_twos_format,
    output logic o_source_ready,
    output ddac_pkg::ddac_pair_t o_sample,
    output logic o_sample_valid,
    input wire logic i_core_ready,
    output logic [1:0] o_i_phase,
    output logic [1:0] o_q_phase,
    output logic o_searching,
    output logic o_cal_tick,
    output logic [5:0] o_i_cal_ref,
    output logic [5:0] o_q_cal_ref
);
    import ddac_pkg::*;
    typedef struct packed {
        logic sck_d;
        logic [4:0] bits;
        logic [15:0] sh;
        logic [7:0] tx;
        logic sdo;
        logic sdo_oe;
        logic [7:0] cal_ctrl;
        logic [5:0] addr;
        logic [5:0] data;
        logic [63:0][5:0] mem;
        logic done_q;
        logic done_i;
        logic [1:0] mst_q;
        logic [1:0] mst_i;
        ddac_cal_st_t cal_st;
        logic run_q;
        logic run_i;
        logic [7:0] div_cnt;
        logic cal_tick;
        logic [5:0] ticks;
        logic [5:0] i_ref;
        logic [5:0] q_ref;
        logic searching;
        logic [7:0] acq_cnt;
        logic [1:0] ph_cnt;
        logic [1:0] auto_ph;
        logic reacq;
        logic ovr;
        logic [1:0] i_field;
        logic [1:0] i_ph;
        logic [1:0] q_ph;
        logic dclk_d;
        logic second;
        logic [SAMPLE_W-1:0] hold;
        logic src_ready;
        logic out_valid;
        ddac_pair_t out_pair;
    } ddac_st_t;
    ddac_st_t r_reg;
    ddac_st_t r_next;
    logic sck_rise;
    logic sck_fall;
    logic [15:0] frame;
    logic wr;
    logic [7:0] wd;
    logic [4:0] wa;
    logic cmd;
    logic edge_hit;
    logic [SAMPLE_W-1:0] conv;
    logic pair_valid;
    ddac_pair_t pair;
    logic fifo_ready;
    logic fifo_valid;
    ddac_pair_t fifo_data;
    logic take;
    logic [8:0] div_n;

    function automatic logic [7:0] rd_reg(input ddac_st_t s, input logic [4:0] a);
        unique case (a)
            A_CAL_CTRL: rd_reg = s.cal_ctrl;
            A_CAL_MEM: rd_reg = {s.done_q, s.done_i, 2'h0, s.mst_q, s.mst_i};
            A_MEM_ADDR: rd_reg = {2'h0, s.addr};
            A_MEM_DATA: rd_reg = {2'h0, s.data};
            A_RT_CTRL: rd_reg = {s.q_ph, 1'b0, s.searching, s.reacq, s.ovr, s.i_ph};
            A_HW_REV: rd_reg = HW_REVISION;
            default: rd_reg = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        r_next = r_reg;
        // Serial port: 8-bit instruction (rw, 2 unused, 5 address) then one byte
        sck_rise = !i_spi_cs_n && i_spi_clk && !r_reg.sck_d;
        sck_fall = !i_spi_cs_n && !i_spi_clk && r_reg.sck_d;
        frame = {r_reg.sh[14:0], i_sdio};
        wr = sck_rise && (r_reg.bits == SPI_BITS - 5'h01) && !frame[15];
        wa = frame[12:8];
        wd = frame[7:0];
        cmd = wr && (wa == A_CAL_CMD);
        r_next.sck_d = i_spi_clk;
        r_next.cal_tick = 1'b0;
        if (i_spi_cs_n)
        begin
            r_next.bits = 5'h00;
            r_next.sdo_oe = 1'b0;
        end
        else if (sck_rise)
        begin
            r_next.sh = frame;
            r_next.bits = r_reg.bits + 5'h01;
            if (r_reg.bits == SPI_INSTR_BITS - 5'h01 && frame[7])
            begin
                r_next.tx = rd_reg(r_reg, frame[4:0]);
                r_next.sdo_oe = 1'b1;
            end
        end
        else if (sck_fall && r_reg.sdo_oe)
        begin
            r_next.sdo = r_reg.tx[7];
            r_next.tx = {r_reg.tx[6:0], 1'b0};
        end
        if (wr)
        begin
            unique case (wa)
                A_CAL_CTRL: r_next.cal_ctrl = wd;
                A_MEM_ADDR: r_next.addr = wd[5:0];
                A_MEM_DATA: r_next.data = wd[5:0];
                A_RT_CTRL:
                begin
                    r_next.reacq = wd[B_REACQ];
                    r_next.ovr = wd[B_OVR];
                    if (r_reg.ovr)
                        r_next.i_field = wd[1:0];
                    if (wd[B_REACQ] && !r_reg.reacq)
                    begin
                        r_next.searching = 1'b1;
                        r_next.acq_cnt = 8'h00;
                    end
                end
                default: ;
            endcase
        end
        if (cmd && wd[B_STORE])
        begin
            r_next.mem[r_reg.addr] = r_reg.data;
            if (r_reg.addr[B_HALF])
                r_next.mst_q = MEM_USER;
            else
                r_next.mst_i = MEM_USER;
        end
        if (cmd && wd[B_FETCH])
            r_next.data = r_reg.mem[r_reg.addr];
        for (int k = 0; k < 64; k++)
        begin
            if (cmd && (k >= 32 ? wd[B_UNCAL_Q] : wd[B_UNCAL_I]))
                r_next.mem[k] = COEFF_DEFAULT;
        end
        if (cmd && wd[B_UNCAL_Q])
            r_next.mst_q = MEM_UNCAL;
        if (cmd && wd[B_UNCAL_I])
            r_next.mst_i = MEM_UNCAL;
        if (cmd && wd[B_CLR_Q])
            r_next.done_q = 1'b0;
        if (cmd && wd[B_CLR_I])
            r_next.done_i = 1'b0;
        // Calibration clock; stopped divider keeps its count
        div_n = (9'h100 >> r_reg.cal_ctrl[2:0]) - 9'h001;
        if (r_reg.cal_ctrl[B_CAL_CLOCK_ENABLE_EN])
        begin
            r_next.div_cnt = r_reg.div_cnt + 8'h01;
            if (r_reg.div_cnt >= div_n[7:0])
            begin
                r_next.div_cnt = 8'h00;
                r_next.cal_tick = 1'b1;
            end
        end
        unique case (r_reg.cal_st)
            CAL_IDLE:
            begin
                if (cmd && wd[B_START])
                begin
                    r_next.cal_st = CAL_RUN;
                    r_next.run_q = r_reg.cal_ctrl[B_SEL_Q];
                    r_next.run_i = r_reg.cal_ctrl[B_SEL_I];
                    r_next.ticks = 6'h00;
                    r_next.q_ref = r_reg.cal_ctrl[B_PRELD_Q] ?
                        r_reg.mem[USER_REF_ADDR] : CAL_REF_FIXED;
                    r_next.i_ref = r_reg.cal_ctrl[B_PRELD_I] ?
                        r_reg.mem[USER_REF_ADDR] : CAL_REF_FIXED;
                end
            end
            CAL_RUN:
            begin
                if (r_reg.cal_tick)
                    r_next.ticks = r_reg.ticks + 6'h01;
                if (r_reg.ticks == CAL_RUN_TICKS)
                    r_next.cal_st = CAL_FINISH;
            end
            CAL_FINISH:
            begin
                // Set wins over a clear in the same cycle
                r_next.cal_st = CAL_IDLE;
                if (r_reg.run_q)
                begin
                    r_next.done_q = 1'b1;
                    r_next.mst_q = MEM_SELF;
                    r_next.mem[6'h20] = r_reg.q_ref;
                end
                if (r_reg.run_i)
                begin
                    r_next.done_i = 1'b1;
                    r_next.mst_i = MEM_SELF;
                    r_next.mem[6'h00] = r_reg.i_ref;
                end
            end
            default: r_next.cal_st = CAL_IDLE;
        endcase
        // Retimer: phase taken from a free count at each data clock rise
        r_next.ph_cnt = r_reg.ph_cnt + 2'h1;
        if (i_data_qualifying_clock && !r_reg.dclk_d)
            r_next.auto_ph = r_reg.ph_cnt;
        if (r_reg.searching && !(wr && wa == A_RT_CTRL && wd[B_REACQ] && !r_reg.reacq))
        begin
            r_next.acq_cnt = r_reg.acq_cnt + 8'h01;
            if (r_reg.acq_cnt == RT_ACQ_CYCLES - 8'h01)
                r_next.searching = 1'b0;
        end
        r_next.i_ph = r_reg.ovr ? r_reg.i_field : r_reg.auto_ph;
        r_next.q_ph = r_reg.ovr ? r_reg.i_field : r_reg.auto_ph;
        if (!r_reg.ovr)
            r_next.i_field = r_reg.auto_ph;
        // DDR capture on the chosen edge of the qualifying clock
        // Edges are seen through this clock, so they must be one clock apart at least
        r_next.dclk_d = i_data_qualifying_clock;
        edge_hit = i_sample_edge_select ? (i_data_qualifying_clock && !r_reg.dclk_d) :
            (!i_data_qualifying_clock && r_reg.dclk_d);
        conv = i_sample_data_bus ^ {i_twos_format, {(SAMPLE_W-1){1'b0}}};
        pair_valid = edge_hit && r_reg.second;
        pair.i = i_channel_order_select ? r_reg.hold : conv;
        pair.q = i_channel_order_select ? conv : r_reg.hold;
        if (edge_hit)
        begin
            r_next.second = !r_reg.second;
            r_next.hold = conv;
        end
        r_next.src_ready = fifo_ready;
        // Output unusable while searching, so nothing leaves the buffer
        take = fifo_valid && !r_reg.searching && (!r_reg.out_valid || i_core_ready);
        if (take)
        begin
            r_next.out_valid = 1'b1;
            r_next.out_pair = fifo_data;
        end
        else if (i_core_ready)
            r_next.out_valid = 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            r_reg <= '0;
            r_reg.searching <= 1'b1;
            r_reg.cal_st <= CAL_IDLE;
        end
        else
            r_reg <= r_next;
    end

    // Pairs arriving while the buffer is full are lost; source must honour ready
    ddac_fifo #(.W($bits(ddac_pair_t)), .D(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_data(pair),
        .i_valid(pair_valid),
        .o_ready(fifo_ready),
        .o_data(fifo_data),
        .o_valid(fifo_valid),
        .i_ready(take)
    );

    assign o_sdio = r_reg.sdo;
    assign o_sdio_oe = r_reg.sdo_oe;
    assign o_source_ready = r_reg.src_ready;
    assign o_sample = r_reg.out_pair;
    assign o_sample_valid = r_reg.out_valid;
    assign o_i_phase = r_reg.i_ph;
    assign o_q_phase = r_reg.q_ph;
    assign o_searching = r_reg.searching;
    assign o_cal_tick = r_reg.cal_tick;
    assign o_i_cal_ref = r_reg.i_ref;
    assign o_q_cal_ref = r_reg.q_ref;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    property p_q_ref;
        cmd && wd[B_START] && r_reg.cal_st == CAL_IDLE && !r_reg.cal_ctrl[B_PRELD_Q]
            |=> r_reg.q_ref == CAL_REF_FIXED;
    endproperty
    a_q_ref: assert property (p_q_ref) else $error("Q ref not 32");
    property p_i_ref;
        cmd && wd[B_START] && r_reg.cal_st == CAL_IDLE && r_reg.cal_ctrl[B_PRELD_I]
            |=> r_reg.i_ref == $past(r_reg.mem[USER_REF_ADDR]);
    endproperty
    a_i_ref: assert property (p_i_ref) else $error("I ref not user value");
    property p_tick_gate;
        !r_reg.cal_ctrl[B_CAL_CLOCK_ENABLE_EN] |=> !r_reg.cal_tick;
    endproperty
    a_tick_gate: assert property (p_tick_gate) else $error("Cal tick while off");
    property p_done;
        r_reg.cal_st == CAL_FINISH && r_reg.run_q |=> r_reg.done_q && r_reg.mst_q == MEM_SELF;
    endproperty
    a_done: assert property (p_done) else $error("Q done not set");
    property p_store;
        cmd && wd[B_STORE] && !wd[B_UNCAL_Q] && !wd[B_UNCAL_I] && r_reg.cal_st != CAL_FINISH
            |=> r_reg.mem[$past(r_reg.addr)] == $past(r_reg.data);
    endproperty
    a_store: assert property (p_store) else $error("Store lost");
    property p_uncal;
        cmd && wd[B_UNCAL_I] && r_reg.cal_st != CAL_FINISH
            |=> r_reg.mst_i == MEM_UNCAL && r_reg.mem[0] == COEFF_DEFAULT;
    endproperty
    a_uncal: assert property (p_uncal) else $error("Uncal failed");
    property p_search_bound;
        $rose(r_reg.searching) |-> ##[1:128] !r_reg.searching;
    endproperty
    a_search_bound: assert property (p_search_bound) else $error("Search too long");
    property p_override;
        r_reg.ovr ##1 r_reg.ovr |=> o_q_phase == $past(r_reg.i_field) && o_i_phase == o_q_phase;
    endproperty
    a_override: assert property (p_override) else $error("Override ignored");
    property p_no_take;
        r_reg.searching && !o_sample_valid |=> !o_sample_valid;
    endproperty
    a_no_take: assert property (p_no_take) else $error("Data left while searching");
    c_cal: cover property (r_reg.cal_st == CAL_FINISH);
    c_out: cover property (o_sample_valid && i_core_ready);
    c_reacq: cover property ($rose(r_reg.searching));
endmodule
`default_nettype wire

// ==== sim/ddac_source.sv ====
`timescale 1ns/100ps
`default_nettype none
module ddac_source (
    input wire logic i_clk,
    input wire logic i_rising,
    output logic o_qclk,
    output logic [ddac_pkg::SAMPLE_W-1:0] o_bus
);
    import ddac_pkg::*;

    initial
    begin
        o_qclk = 1'b0;
        o_bus = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock stands low between words; the word is valid only around the chosen edge,
    // the other edge sees its inverse, as a real DDR source would show
    // Edges at least eight cycles apart, well inside the rate ceiling
    task automatic send(input logic [SAMPLE_W-1:0] w);
        @(posedge i_clk) o_bus <= i_rising ? w : ~w;
        repeat (4) @(posedge i_clk);
        o_qclk <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_bus <= i_rising ? ~w : w;
        repeat (4) @(posedge i_clk);
        o_qclk <= 1'b0;
        repeat (4) @(posedge i_clk);
        o_bus <= ~w;
    endtask
endmodule
`default_nettype wire

// ==== sim/test_dual_dac_cal_retimer_ddr_input.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_dual_dac_cal_retimer_ddr_input;
    import ddac_pkg::*;
    typedef struct packed {logic wr; logic [4:0] a; logic [7:0] d; logic [7:0] e;} ddac_row_t;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic spi_clk = 1'b0;
    logic cs_n = 1'b1;
    logic sdio = 1'b0;
    logic order = 1'b1;
    logic edge_sel = 1'b1;
    logic twos = 1'b0;
    logic core_rdy = 1'b1;
    logic sdo, sdo_oe, qclk, src_rdy, s_valid, srch, tick, oe_seen;
    logic [SAMPLE_W-1:0] bus, a, b, fi, fq;
    ddac_pair_t smp;
    logic [1:0] iph, qph;
    logic [5:0] iref, qref;
    logic [7:0] v;
    ddac_row_t rows [7];
    int dv [4] = '{0, 1, 6, 7};
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int g, n;

    always #10 i_clk = ~i_clk;

    ddac_top i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_spi_clk(spi_clk),
        .i_spi_cs_n(cs_n), .i_sdio(sdio), .o_sdio(sdo), .o_sdio_oe(sdo_oe),
        .i_data_qualifying_clock(qclk), .i_sample_data_bus(bus),
        .i_channel_order_select(order), .i_sample_edge_select(edge_sel),
        .i_twos_format(twos), .o_source_ready(src_rdy), .o_sample(smp),
        .o_sample_valid(s_valid), .i_core_ready(core_rdy), .o_i_phase(iph),
        .o_q_phase(qph), .o_searching(srch), .o_cal_tick(tick),
        .o_i_cal_ref(iref), .o_q_cal_ref(qref));

    ddac_source i_src (.i_clk(i_clk), .i_rising(edge_sel), .o_qclk(qclk), .o_bus(bus));

    ////////////////////////////////////////////////////////////////////////////////
    task finish_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Run is well under 20000 cycles; a hang counts as a mismatch
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_total++;
            finish_test();
        end
    end

    task check(input string nm, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    task clk_n(input int k);
        repeat (k) @(posedge i_clk);
    endtask

    // Serial clock at i_clk/8; bits change on the fall, read bits sampled before the rise
    task spi(input logic r, input logic [4:0] ad, input logic [7:0] d);
        logic [15:0] f;
        f = {r, 2'b00, ad, d};
        v = 8'h00;
        @(posedge i_clk) cs_n <= 1'b0;
        for (int k = 15; k >= 0; k--)
        begin
            sdio <= f[k];
            spi_clk <= 1'b0;
            clk_n(4);
            if (k < 8)
                v[k] = sdo;
            spi_clk <= 1'b1;
            clk_n(4);
        end
        oe_seen = sdo_oe;
        spi_clk <= 1'b0;
        clk_n(4);
        cs_n <= 1'b1;
        clk_n(4);
    endtask

    task wr(input logic [4:0] ad, input logic [7:0] d);
        spi(1'b0, ad, d);
    endtask

    task rd(input logic [4:0] ad);
        spi(1'b1, ad, 8'h00);
    endtask

    task tick_gap;
        for (n = 0; n < 600 && tick !== 1'b1; n++)
            @(posedge i_clk);
        g = 0;
        do
        begin
            @(posedge i_clk);
            g++;
        end
        while (tick !== 1'b1 && g < 600);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rows = '{'{1'b0, A_HW_REV, 8'h00, HW_REVISION}, '{1'b1, A_HW_REV, 8'hAA, HW_REVISION},
            '{1'b1, 5'h13, 8'h5A, 8'h00}, '{1'b0, A_CAL_MEM, 8'h00, 8'h00},
            '{1'b1, A_MEM_ADDR, 8'h3F, 8'h3F}, '{1'b1, A_MEM_DATA, 8'h2A, 8'h2A},
            '{1'b1, A_CAL_CTRL, 8'h37, 8'h37}};
        clk_n(16);
        check("search_in_reset", srch, 1'b1);
        i_reset_n <= 1'b1;
        clk_n(50);
        check("search_early", srch, 1'b1);
        clk_n(78);
        check("search_done", srch, 1'b0);
        foreach (rows[j])
        begin
            if (rows[j].wr)
                wr(rows[j].a, rows[j].d);
            rd(rows[j].a);
            check("reg_table", v, rows[j].e);
            check("sdio_oe", {oe_seen, sdo_oe}, 2'b10);
        end
        // Second period is measured, the first may be cut by the divider change
        foreach (dv[j])
        begin
            wr(A_CAL_CTRL, {5'h01, 3'(dv[j])});
            tick_gap();
            tick_gap();
            check("cal_div", g, 256 >> dv[j]);
        end
        wr(A_CAL_CTRL, 8'h07);
        n = 0;
        repeat (300) @(posedge i_clk) n += int'(tick === 1'b1);
        check("cal_clk_off", n, 0);
        wr(A_MEM_ADDR, 8'h05);
        wr(A_CAL_CMD, 8'h08);
        wr(A_MEM_DATA, 8'h11);
        wr(A_CAL_CMD, 8'h00);
        rd(A_MEM_DATA);
        check("zero_cmd", v, 8'h11);
        wr(A_CAL_CMD, 8'h04);
        rd(A_MEM_DATA);
        check("fetch", v, 8'h2A);
        rd(A_CAL_MEM);
        check("user_state", v, {6'h00, MEM_USER});
        wr(A_CAL_CMD, 8'h01);
        rd(A_CAL_MEM);
        check("uncal_state", v, 8'h00);
        wr(A_CAL_CMD, 8'h04);
        rd(A_MEM_DATA);
        check("uncal_coeff", v, {2'b00, COEFF_DEFAULT});
        wr(A_MEM_ADDR, {2'b00, USER_REF_ADDR});
        wr(A_MEM_DATA, 8'h15);
        wr(A_CAL_CMD, 8'h08);
        wr(A_CAL_CTRL, 8'h3F);
        wr(A_CAL_CMD, 8'h10);
        check("i_ref_fixed", iref, CAL_REF_FIXED);
        check("q_ref_fixed", qref, CAL_REF_FIXED);
        clk_n(100);
        rd(A_CAL_MEM);
        check("cal_both", v, {2'b11, 2'b00, MEM_SELF, MEM_SELF});
        wr(A_CAL_CMD, 8'hC0);
        rd(A_CAL_MEM);
        check("flag_clear", v, {4'h0, MEM_SELF, MEM_SELF});
        wr(A_CAL_CTRL, 8'hDF);
        wr(A_CAL_CMD, 8'h10);
        check("i_ref_user", iref, 6'h15);
        check("q_ref_user", qref, 6'h15);
        clk_n(100);
        rd(A_CAL_MEM);
        check("cal_i_only", v, {2'b01, 2'b00, MEM_SELF, MEM_SELF});
        wr(A_RT_CTRL, 8'h04);
        wr(A_RT_CTRL, 8'h06);
        check("i_phase_ovr", iph, 2'h2);
        check("q_phase_ovr", qph, 2'h2);
        rd(A_RT_CTRL);
        check("phase_read", {v[7:6], v[2:0]}, 5'b10110);
        wr(A_RT_CTRL, 8'h0C);
        check("reacq", srch, 1'b1);
        clk_n(128);
        check("reacq_done", srch, 1'b0);
        wr(A_RT_CTRL, 8'h0C);
        check("reacq_level", srch, 1'b0);
        wr(A_RT_CTRL, 8'h00);
        // Consumer holds off so each pair stands until it is looked at
        core_rdy <= 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            order <= k[1];
            edge_sel <= k[0];
            twos <= k[0] ^ k[1];
            clk_n(2);
            a = 14'h1234 + 14'(k);
            b = 14'h2C0F;
            fi = order ? a : b;
            fq = order ? b : a;
            fi[SAMPLE_W-1] ^= twos;
            fq[SAMPLE_W-1] ^= twos;
            i_src.send(a);
            i_src.send(b);
            for (n = 0; n < 50 && s_valid !== 1'b1; n++)
                @(posedge i_clk);
            check("sample_i", smp.i, fi);
            check("sample_q", smp.q, fq);
            check("sample_valid", s_valid, 1'b1);
            core_rdy <= 1'b1;
            clk_n(1);
            core_rdy <= 1'b0;
        end
        // Consumer stalls while the source keeps sending, then drains
        repeat (18)
        begin
            i_src.send(a);
            i_src.send(b);
        end
        clk_n(4);
        check("buf_full", src_rdy, 1'b0);
        core_rdy <= 1'b1;
        clk_n(60);
        check("buf_empty", {src_rdy, s_valid}, 2'b10);
        finish_test();
    end
endmodule
`default_nettype wire
